// file: common/sfe_pkg.sv
/*
  sfe_pkg: shared constants, types and helpers of the serial front end
  of a 16-bit successive-approximation converter.
  Assumes: a 100 MHz system clock and a host-driven serial clock.
*/
package sfe_pkg;

  ////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 10;  // system clock period
  localparam int T_ACQ_NS = 729;      // least acquisition time
  localparam int ACQ_CYC = (T_ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////
  // command register layout
  localparam logic [7:0] CMD_RESET = 8'h06;  // power-up contents
  localparam int CMD_CH_LSB = 5;             // channel field
  localparam int CMD_SCAN_LSB = 3;           // scan field
  localparam int CMD_PD_LSB = 1;             // power-down field
  localparam int CMD_CLK = 0;                // 1: internal clock
  localparam logic [1:0] PD_EXT = 2'h3;      // external reference
  localparam logic [1:0] SCAN_ALL = 2'h1;    // 0 through last
  localparam logic [1:0] SCAN_UPPER = 2'h2;  // 4 through last
  localparam logic [1:0] SCAN_REPEAT = 2'h3; // one channel eight times
  localparam logic [2:0] SCAN_UPPER_FIRST = 3'h4;
  localparam logic [2:0] SCAN_REPEAT_LAST = 3'h7; // eight passes

  ////////////////////////////////////////////////////////////////////
  // serial clock edge numbers within a frame
  localparam logic [5:0] WIDTH_EDGE = 6'h01;
  localparam logic [5:0] CH_SEL_EDGE = 6'h03;
  localparam logic [5:0] CMD_LAST_EDGE = 6'h08;
  localparam logic [5:0] HOLD_FALL_8 = 6'h06;
  localparam logic [5:0] HOLD_FALL_16 = 6'h0F;
  localparam logic [5:0] MSB_FALL_8 = 6'h08;
  localparam logic [5:0] MSB_FALL_16 = 6'h10;
  localparam logic [5:0] RES_SPAN = 6'h10;   // result bits out
  localparam logic [5:0] CNT_MAX = 6'h3F;
  localparam logic [15:0] RES_MSB = 16'h8000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACQ  = 3'b010,
    ST_CONV = 3'b100
  } sfe_state_t;

  // falling edge that ends acquisition
  function automatic logic [5:0] sfe_hold_fall(input logic w16);
    return w16 ? HOLD_FALL_16 : HOLD_FALL_8;
  endfunction

  // falling edge that presents the MSB
  function automatic logic [5:0] sfe_msb_fall(input logic w16);
    return w16 ? MSB_FALL_16 : MSB_FALL_8;
  endfunction

endpackage

// file: verilog/sfe_sync.sv
/*
  sfe_sync: three-stage synchroniser for a group of levels.
  Assumes: each bit is an independent level from another domain.
*/
module sfe_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // three stages plus the accepted level
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } sfe_sync_t;

  sfe_sync_t st;
  sfe_sync_t next_st;

  // a change counts once stages two and three agree
  always_comb begin
    next_st = st;
    next_st.s1 = async_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.lvl = (st.s2 & st.s3) | (st.lvl & (st.s2 | st.s3));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= {INIT, INIT, INIT, INIT};
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.lvl;

endmodule

// file: verilog/sfe_top.sv
/*
  sfe_top: serial interface and conversion sequencer of the converter.
  Link logic runs on the host serial clock; sequencing and the
  successive-approximation engine run on the system clock.
  Assumes: an analog core with a comparator (comp_i high when the
  held input is at or above dac_code_o), settled within one cycle.
*/
module sfe_top
  import sfe_pkg::*;
#(
  parameter int ACQ_CYCLES = ACQ_CYC  // internal acquisition length
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  input wire logic frame_sync_in_i,
  input wire logic transfer_width_select_i,
  input wire logic comp_i,
  output logic dout_o,
  output logic dout_oe_o,
  output logic frame_sync_out_o,
  output logic eoc_n_o,
  output logic track_o,
  output logic powerdown_o,
  output logic ext_ref_o,
  output logic [1:0] ref_mode_o,
  output logic [2:0] channel_o,
  output logic [15:0] dac_code_o
);

  ////////////////////////////////////////////////////////////////////
  // elaboration checks

  // acquisition counter is eight bits wide
  if (ACQ_CYCLES < 1 || ACQ_CYCLES > 256) begin : g_chk
    $error("ACQ_CYCLES must lie in 1..256");
  end

  localparam logic [7:0] ACQ_LOAD = 8'(ACQ_CYCLES - 1);
  localparam int ACQ_WAIT = ACQ_CYCLES;  // for checks
  localparam logic [3:0] SYNC_INIT = 4'h8;  // deselected

  ////////////////////////////////////////////////////////////////////
  // state types

  // link state, rising serial clock edge
  typedef struct packed {
    logic [5:0] cnt;       // rising edges in frame
    logic [7:0] sh;        // command shifter
    logic [7:0] cmd_word;  // captured command
    logic [2:0] chan;      // early channel
    logic chan_vld;        // channel captured
    logic cmd_vld;         // command captured
    logic w16;             // 16-bit transfers
    logic dsp;             // frame started by frame sync
  } sfe_lnk_t;

  // link state, falling serial clock edge
  typedef struct packed {
    logic hold;    // sample taken
    logic dout;    // serial result bit
    logic fs_out;  // frame-sync pulse
  } sfe_neg_t;

  // system clock state
  typedef struct packed {
    sfe_state_t state;
    logic [7:0] cmd;       // command register
    logic [2:0] chan;      // active channel
    logic [2:0] rep;       // repeat scans left
    logic track;           // track/hold switch
    logic eoc_n;           // end of conversion
    logic [15:0] res;      // result bits
    logic [15:0] dac;      // trial code
    logic [3:0] bidx;      // bit under trial
    logic [7:0] acq;       // acquisition count
    logic [3:0] prev;      // previous sync levels
    logic pwrdn;           // power-down applied
    logic oe;              // DOUT enable
    logic [1:0] ref_mode;  // power-down selection
    logic ext_ref;         // external reference
  } sfe_sys_t;

  sfe_lnk_t lr;
  sfe_lnk_t next_lr;
  sfe_neg_t nr;
  sfe_neg_t next_nr;
  sfe_sys_t sr;
  sfe_sys_t next_sr;

  logic [3:0] sync;   // cs_n, chan_vld, cmd_vld, hold
  logic [5:0] msb;    // MSB falling edge number
  logic [5:0] off;    // bit offset from MSB
  logic cs_rise;      // deselect seen
  logic cs_fall;      // select seen
  logic ch_rise;      // channel ready
  logic cm_rise;      // command ready
  logic hd_rise;      // sample taken
  logic internal;     // internal clock mode
  logic more;         // scan continues
  logic [1:0] scan;   // scan field
  logic [2:0] last;   // last scan channel

  ////////////////////////////////////////////////////////////////////
  // link, rising edge: command in

  // command bits latch on rising serial clock
  always_comb begin
    next_lr = lr;
    if (!frame_sync_in_i) begin
      // frame sync restarts the frame
      next_lr = '0;
      next_lr.dsp = 1'b1;
    end else begin
      if (lr.cnt != CNT_MAX) begin
        next_lr.cnt = lr.cnt + 6'h01;
      end
      // shift command bits in
      if (lr.cnt < CMD_LAST_EDGE) begin
        next_lr.sh = {lr.sh[6:0], din_i};
      end
      // width taken at first edge
      if (next_lr.cnt == WIDTH_EDGE) begin
        next_lr.w16 = transfer_width_select_i;
      end
      // channel known at third edge
      if (next_lr.cnt == CH_SEL_EDGE) begin
        next_lr.chan = {lr.sh[1:0], din_i};
        next_lr.chan_vld = 1'b1;
      end
      // whole command at eighth edge
      if (next_lr.cnt == CMD_LAST_EDGE) begin
        next_lr.cmd_word = {lr.sh[6:0], din_i};
        next_lr.cmd_vld = 1'b1;
      end
    end
  end

  // deselect clears the frame at once
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      lr <= '0;
    end else begin
      lr <= next_lr;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // link, falling edge: sample and result out

  assign msb = sfe_msb_fall(lr.w16);
  assign off = lr.cnt - msb;

  // falling edge n sees edge count n
  always_comb begin
    next_nr = nr;
    // acquisition ends at edge 6 or 15
    if (lr.cnt == sfe_hold_fall(lr.w16)) begin
      next_nr.hold = 1'b1;
    end
    // restarted frame tracks again
    if (lr.cnt == 6'h00) begin
      next_nr.hold = 1'b0;
    end
    // pulse marks the MSB in DSP frames
    next_nr.fs_out = lr.dsp && (lr.cnt == msb);
    // low before the result, zeros after
    next_nr.dout = 1'b0;
    if (lr.cnt >= msb && lr.cnt < msb + RES_SPAN) begin
      // result bits settle MSB first, long before their slot
      next_nr.dout = sr.res[4'hF - off[3:0]];
    end
  end

  // DOUT changes on falling serial clock
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      nr <= '0;
    end else begin
      nr <= next_nr;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // crossing into the system clock

  // link levels are held stable while set
  sfe_sync #(
    .WIDTH(4),
    .INIT(SYNC_INIT)
  ) u_sync (
    .clk_i(sys_clk_i),
    .rst_i(rst_i),
    .async_i({cs_n_i, lr.chan_vld, lr.cmd_vld, nr.hold}),
    .sync_o(sync)
  );

  assign cs_rise = sync[3] & ~sr.prev[3];
  assign cs_fall = ~sync[3] & sr.prev[3];
  assign ch_rise = sync[2] & ~sr.prev[2];
  assign cm_rise = sync[1] & ~sr.prev[1];
  assign hd_rise = sync[0] & ~sr.prev[0];

  assign internal = sr.cmd[CMD_CLK];
  assign scan = sr.cmd[CMD_SCAN_LSB +: 2];
  assign last = sr.cmd[CMD_CH_LSB +: 3];

  // another pass of an internal scan
  always_comb begin
    more = 1'b0;
    if (internal && (scan == SCAN_ALL || scan == SCAN_UPPER)) begin
      more = sr.chan != last;
    end else if (internal && scan == SCAN_REPEAT) begin
      more = sr.rep != 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sequencer and successive approximation

  // one next-state for the whole system side
  always_comb begin
    next_sr = sr;
    next_sr.prev = sync;
    // deselect applies the chosen power-down
    next_sr.pwrdn = sync[3];
    next_sr.oe = ~sync[3];
    next_sr.ref_mode = sr.cmd[CMD_PD_LSB +: 2];
    // full scale is the chosen reference
    next_sr.ext_ref = sr.cmd[CMD_PD_LSB +: 2] == PD_EXT;
    // select: back to track, flag cleared
    if (cs_fall) begin
      next_sr.track = 1'b1;
      next_sr.eoc_n = 1'b1;
    end
    // external mode channel from third edge
    if (ch_rise && !internal) begin
      next_sr.chan = lr.chan;
    end
    // command register load
    if (cm_rise) begin
      next_sr.cmd = lr.cmd_word;
      // internal clock starts its own cycle
      if (lr.cmd_word[CMD_CLK] && sr.state == ST_IDLE) begin
        next_sr.state = ST_ACQ;
        next_sr.acq = ACQ_LOAD;
        next_sr.track = 1'b1;
        next_sr.eoc_n = 1'b1;
        next_sr.rep = SCAN_REPEAT_LAST;
        unique case (lr.cmd_word[CMD_SCAN_LSB +: 2])
          SCAN_ALL: next_sr.chan = 3'h0;
          SCAN_UPPER: next_sr.chan = SCAN_UPPER_FIRST;
          default: next_sr.chan = lr.cmd_word[CMD_CH_LSB +: 3];
        endcase
      end
    end
    unique case (sr.state)
      ST_IDLE: begin
        // serial clock sample, external clock only
        if (hd_rise && !internal) begin
          next_sr.state = ST_CONV;
          next_sr.track = 1'b0;
          next_sr.bidx = 4'hF;
          next_sr.res = '0;
          next_sr.dac = RES_MSB;
        end
      end
      ST_ACQ: begin
        // internal acquisition window
        if (sr.acq == 8'h00) begin
          next_sr.state = ST_CONV;
          next_sr.track = 1'b0;
          next_sr.bidx = 4'hF;
          next_sr.res = '0;
          next_sr.dac = RES_MSB;
        end else begin
          next_sr.acq = sr.acq - 8'h01;
        end
      end
      ST_CONV: begin
        // keep or drop the bit under trial
        next_sr.res[sr.bidx] = comp_i;
        next_sr.dac[sr.bidx] = comp_i;
        if (sr.bidx != 4'h0) begin
          next_sr.dac[sr.bidx - 4'h1] = 1'b1;
          next_sr.bidx = sr.bidx - 4'h1;
        end else if (more) begin
          // next pass of the scan
          next_sr.state = ST_ACQ;
          next_sr.acq = ACQ_LOAD;
          next_sr.track = 1'b1;
          if (scan == SCAN_REPEAT) begin
            next_sr.rep = sr.rep - 3'h1;
          end else begin
            next_sr.chan = sr.chan + 3'h1;
          end
        end else begin
          // all 16 bits resolved
          next_sr.state = ST_IDLE;
          next_sr.eoc_n = 1'b0;
        end
      end
    endcase
  end

  // system state register
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sr <= '0;
      sr.state <= ST_IDLE;
      sr.cmd <= CMD_RESET;
      sr.track <= 1'b1;
      sr.eoc_n <= 1'b1;
      sr.prev <= SYNC_INIT;
      sr.pwrdn <= 1'b1;
      sr.ref_mode <= CMD_RESET[CMD_PD_LSB +: 2];
      sr.ext_ref <= CMD_RESET[CMD_PD_LSB +: 2] == PD_EXT;
    end else begin
      sr <= next_sr;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops

  assign dout_o = nr.dout;
  assign frame_sync_out_o = nr.fs_out;
  assign dout_oe_o = sr.oe;
  assign eoc_n_o = sr.eoc_n;
  assign track_o = sr.track;
  assign powerdown_o = sr.pwrdn;
  assign ext_ref_o = sr.ext_ref;
  assign ref_mode_o = sr.ref_mode;
  assign channel_o = sr.chan;
  assign dac_code_o = sr.dac;

  ////////////////////////////////////////////////////////////////////
  // checks, system clock

  cmd_reset_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    $fell(rst_i) |-> (sr.cmd == CMD_RESET && eoc_n_o))
    else $error("command register not at default after reset");

  desel_pd_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    cs_rise |=> (powerdown_o && !dout_oe_o))
    else $error("deselect did not power down or release DOUT");

  ext_shut_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (sync[3] && ext_ref_o) [*2] |-> powerdown_o)
    else $error("external reference not shut down while deselected");

  wake_track_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    cs_fall |=> (!powerdown_o && track_o && eoc_n_o))
    else $error("select did not wake and return to track");

  ext_start_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (hd_rise && sr.state == ST_IDLE && !internal) |=>
      (sr.state == ST_CONV && !track_o && dac_code_o == RES_MSB))
    else $error("sample edge did not start the conversion");

  conv_len_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    ($rose(sr.state == ST_CONV) && !internal) |->
      ##15 (sr.state == ST_CONV && sr.bidx == 4'h0)
      ##1 (sr.state == ST_IDLE && !eoc_n_o))
    else $error("conversion did not take sixteen steps");

  int_acq_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    $rose(sr.state == ST_ACQ) |->
      track_o ##ACQ_WAIT (sr.state == ST_CONV && !track_o))
    else $error("internal acquisition length wrong");

  ////////////////////////////////////////////////////////////////////
  // checks, serial clock

  width_a: assert property (
    @(posedge sclk_i) disable iff (cs_n_i)
    (lr.cnt == 6'h00 && frame_sync_in_i) |=>
      (lr.w16 == $past(transfer_width_select_i)))
    else $error("transfer width not taken at first edge");

  dout_low_a: assert property (
    @(negedge sclk_i) disable iff (cs_n_i)
    (lr.cnt != 6'h00 && lr.cnt <= msb) |-> !dout_o)
    else $error("DOUT not low before the MSB edge");

  acq_win_a: assert property (
    @(negedge sclk_i) disable iff (cs_n_i)
    (lr.cnt == sfe_hold_fall(lr.w16) + 6'h01) |-> nr.hold)
    else $error("sample not taken at the acquisition end");

  fsync_a: assert property (
    @(negedge sclk_i) disable iff (cs_n_i)
    (lr.dsp && lr.cnt == msb + 6'h01) |->
      frame_sync_out_o ##1 !frame_sync_out_o)
    else $error("frame-sync pulse missing at the MSB");

  ext_done_c: cover property (
    @(posedge sys_clk_i) disable iff (rst_i)
    $fell(eoc_n_o) && !internal);

  scan_done_c: cover property (
    @(posedge sys_clk_i) disable iff (rst_i)
    $fell(eoc_n_o) && internal && scan == SCAN_REPEAT);

  dsp_pulse_c: cover property (
    @(negedge sclk_i) disable iff (cs_n_i)
    frame_sync_out_o && lr.w16);

endmodule

// file: tb/sfe_host_model.sv
/*
  sfe_host_model: serial bus master that faces the converter front end.
  Assumes: the bench calls one task at a time; the clock parks low outside frames.
*/
module sfe_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o,
  output logic frame_sync_n_o,
  input wire logic dout_i,
  input wire logic frame_sync_i
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF_NS = 40;  // 80 ns serial clock

  ////////////////////////////////////////////////////////////////////////////
  // idle levels: deselected, clock parked, frame sync tied high
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
    frame_sync_n_o = 1'b1;
  end

  // one clock period: data set at the fall, dout sampled before the rise
  task automatic cyc(input logic d, output logic seen, output logic fs);
    din_o = d;
    #(HALF_NS / 2);
    seen = dout_i;
    fs = frame_sync_i;
    #(HALF_NS / 2);
    sclk_o = 1'b1;
    #HALF_NS;
    sclk_o = 1'b0;
  endtask

  // chip select level set by the bench
  task automatic select(input logic v);
    cs_n_o = v;
  endtask

  // clock and data noise while deselected
  task automatic stray(input int n);
    logic s;
    logic f;
    for (int k = 0; k < n; k++) cyc(~din_o, s, f);
  endtask

  // whole frame: command out, early zeros, result and frame-sync timing in
  task automatic frame(input logic [7:0] cmd, input logic w16, input logic dsp,
                       output logic [15:0] res, output int bad, output logic fs_ok);
    int m;
    logic s;
    logic f;
    m = w16 ? 16 : 8;
    res = '0;
    bad = 0;
    fs_ok = 1'b1;
    cs_n_o = 1'b0;
    #(2 * HALF_NS);
    if (dsp) begin
      frame_sync_n_o = 1'b0;
      cyc(~din_o, s, f);
      frame_sync_n_o = 1'b1;
    end
    for (int k = 1; k <= m + 16; k++) begin
      cyc(k <= 8 ? cmd[8-k] : ~din_o, s, f);
      if (k >= 2 && k <= m && s !== 1'b0) bad++;
      if (k > m) res = {res[14:0], s};
      if (k > 1 && f !== (dsp && k == m + 1)) fs_ok = 1'b0;
    end
    #HALF_NS;
    din_o = ~din_o;  // data line toggled
    cs_n_o = 1'b1;
  endtask
endmodule

// file: tb/sfe_top_tb_top.sv
/*
  sfe_top_tb_top: self-checking bench of the converter serial front end.
  Assumes: an ideal comparator against a held level; the host model drives the link.
*/
module sfe_top_tb_top
  import sfe_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_i, rst_i, transfer_width_select_i;
  logic sclk, cs_n, din, fs_in_n;  // host side link
  logic dout_o, dout_oe_o, frame_sync_out_o, eoc_n_o, track_o, powerdown_o, ext_ref_o;
  logic [1:0] ref_mode_o;
  logic [2:0] channel_o;
  logic [15:0] dac_code_o, level;  // level: held analog sample
  logic comp;
  int miscompares = 0;
  int total_checks = 0;

  ////////////////////////////////////////////////////////////////////////////
  // clock and ideal comparator
  always #5 sys_clk_i = ~sys_clk_i;
  assign comp = (level >= dac_code_o);

  sfe_top #(.ACQ_CYCLES(4)) sfe_top_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
    .frame_sync_in_i(fs_in_n), .transfer_width_select_i(transfer_width_select_i),
    .comp_i(comp), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
    .frame_sync_out_o(frame_sync_out_o), .eoc_n_o(eoc_n_o), .track_o(track_o),
    .powerdown_o(powerdown_o), .ext_ref_o(ext_ref_o), .ref_mode_o(ref_mode_o),
    .channel_o(channel_o), .dac_code_o(dac_code_o));

  sfe_host_model sfe_host_model_inst (
    .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .frame_sync_n_o(fs_in_n),
    .dout_i(dout_o), .frame_sync_i(frame_sync_out_o));

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask

  task automatic chk1(input string name, input logic exp, input logic got);
    chk(name, {15'h0, exp}, {15'h0, got});
  endtask

  // one frame plus the checks around it, then a re-arm cycle of chip select
  task automatic run_frame(input logic [7:0] cmd, input logic w16, input logic dsp,
                           input logic [15:0] lvl);
    logic [15:0] res;
    int bad;
    logic fs_ok;
    level = lvl;
    transfer_width_select_i = w16;
    fork
      sfe_host_model_inst.frame(cmd, w16, dsp, res, bad, fs_ok);
      begin
        tick(30);
        chk1("powerdown", 1'b0, powerdown_o);
        chk1("dout_oe", 1'b1, dout_oe_o);
      end
    join
    if (!cmd[0]) chk("result", lvl, res);
    chk("early zeros", 16'h0000, bad[15:0]);
    chk1("frame sync", 1'b1, fs_ok);
    chk("channel", {13'h0, cmd[7:5]}, {13'h0, channel_o});
    chk("ref mode", {14'h0, cmd[2:1]}, {14'h0, ref_mode_o});
    chk1("ext ref", &cmd[2:1], ext_ref_o);
    tick(10);
    chk1("shutdown", 1'b1, powerdown_o);
    chk1("dout off", 1'b0, dout_oe_o);
    chk1("eoc", 1'b0, eoc_n_o);
    chk1("hold", 1'b0, track_o);
    chk("dac", lvl, dac_code_o);
    sfe_host_model_inst.select(1'b0);
    tick(10);
    chk1("track", 1'b1, track_o);
    chk1("eoc clear", 1'b1, eoc_n_o);
    sfe_host_model_inst.select(1'b1);
    tick(10);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    chk1("eoc", 1'b1, eoc_n_o);
    chk1("track", 1'b1, track_o);
    chk1("powerdown", 1'b1, powerdown_o);
    chk1("dout_oe", 1'b0, dout_oe_o);
    chk1("ext ref", 1'b1, ext_ref_o);
    chk("ref mode", {14'h0, CMD_RESET[2:1]}, {14'h0, ref_mode_o});
    chk("channel", {13'h0, CMD_RESET[7:5]}, {13'h0, channel_o});
    chk("dac", 16'h0000, dac_code_o);
    $display("test reset done");
  endtask

  task automatic t_ext8;
    run_frame(8'hA6, 1'b0, 1'b0, 16'hA5C3);
    $display("test ext8 done");
  endtask

  // stray clocks while deselected, then a full-scale 16-bit frame and a reset
  task automatic t_ext16;
    sfe_host_model_inst.stray(5);
    chk1("stray shutdown", 1'b1, powerdown_o);
    run_frame(8'hE0, 1'b1, 1'b0, 16'hFFFF);
    rst_i = 1'b1;
    tick(4);
    rst_i = 1'b0;
    tick(8);
    chk("reset ref mode", {14'h0, CMD_RESET[2:1]}, {14'h0, ref_mode_o});
    $display("test ext16 done");
  endtask

  task automatic t_dsp;
    run_frame(8'h46, 1'b0, 1'b1, 16'h0001);
    $display("test dsp done");
  endtask

  // first frame loads internal clocking; the second then scans channels 0 to 1
  task automatic t_int;
    run_frame(8'h27, 1'b0, 1'b0, 16'h1234);
    run_frame(8'h2F, 1'b0, 1'b0, 16'h4321);
    $display("test internal done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    sys_clk_i = 1'b0;
    rst_i = 1'b1;
    transfer_width_select_i = 1'b0;
    level = 16'h0000;
    tick(8);
    rst_i = 1'b0;
    tick(8);
    t_reset;
    t_ext8;
    t_ext16;
    t_dsp;
    t_int;
    complete_run;
  end

  // watchdog: the frames need about 13 us, allow about fifteen times that
  initial begin
    #200_000;
    miscompares++;
    complete_run;
  end
endmodule
